/* src/fpls_params.svh */
`ifndef FPLS_PARAMS_SVH
`define FPLS_PARAMS_SVH
// register byte offsets
`define FPLS_OFF_OPA_LO    8'h00
`define FPLS_OFF_OPA_HI    8'h04
`define FPLS_OFF_OPB_LO    8'h08
`define FPLS_OFF_OPB_HI    8'h0c
`define FPLS_OFF_CMD       8'h10
`define FPLS_OFF_STATUS    8'h14
`define FPLS_OFF_FP_STATUS_CONTROL_REG     8'h18
`define FPLS_OFF_COND      8'h1c
`define FPLS_OFF_RESULT_LO 8'h20
`define FPLS_OFF_RESULT_HI 8'h24
`define FPLS_OFF_ADDR      8'h28
`define FPLS_OFF_ACCESS    8'h2c
`define FPLS_OFF_LSU_STAT  8'h30
`define FPLS_OFF_INDEX     8'h34
// command register fields
`define FPLS_CMD_OP_LSB    0
`define FPLS_CMD_OP_W      4
`define FPLS_CMD_REC_BIT   4
`define FPLS_CMD_FM_LSB    8
`define FPLS_CMD_FM_W      8
// access register fields
`define FPLS_ACC_SIZE_LSB  0
`define FPLS_ACC_SIZE_W    4
`define FPLS_ACC_KIND_LSB  4
`define FPLS_ACC_MODE_LSB  8
`define FPLS_ACC_LE_BIT    12
`define FPLS_ACC_FAULT_BIT 13
`define FPLS_ACC_TLBM_BIT  14
`define FPLS_ACC_STORE_BIT 15
// fp_status_control_reg compare field, invalid-op bits and exception summary bit
`define FPLS_FPCC_LSB      12
`define FPLS_VXSNAN_BIT    24
`define FPLS_VXVC_BIT      19
`define FPLS_FX_BIT        31
// timing counts in cycles, then an all-zero word
`define FPLS_FP_LATENCY    4'h3
`define FPLS_TLB_RELOAD    4'h4
`define FPLS_RESET_ZERO    32'h0000_0000
`endif

/* src/fpls_pkg.sv */
package fpls_pkg;
    typedef enum logic [3:0] {
        FPLS_OP_NONE  = 4'h0,
        FPLS_OP_CMPU  = 4'h1,
        FPLS_OP_CMPO  = 4'h2,
        FPLS_OP_MR    = 4'h3,
        FPLS_OP_NEG   = 4'h4,
        FPLS_OP_ABS   = 4'h5,
        FPLS_OP_NABS  = 4'h6,
        FPLS_OP_MFFS  = 4'h7,
        FPLS_OP_MTFSF = 4'h8
    } fpls_op_t;
    // access kinds
    typedef enum logic [1:0] {
        FPLS_K_SINGLE = 2'h0,
        FPLS_K_MULT   = 2'h1,
        FPLS_K_STRING = 2'h2
    } fpls_kind_t;
    // address modes
    typedef enum logic [1:0] {
        FPLS_M_DISP  = 2'h0,
        FPLS_M_INDEX = 2'h1,
        FPLS_M_REG   = 2'h2
    } fpls_mode_t;
    typedef enum logic [5:0] {
        FPLS_S_IDLE  = 6'b000001,
        FPLS_S_DRAIN = 6'b000010,
        FPLS_S_EXEC  = 6'b000100,
        FPLS_S_ACC1  = 6'b001000,
        FPLS_S_ACC2  = 6'b010000,
        FPLS_S_TLB   = 6'b100000
    } fpls_state_t;
endpackage : fpls_pkg

/* src/fpls_core.sv */
// Operation
// [R1] compare treats +0 and -0 as equal
// [R2] compare with record bit leaves target condition field undefined
// [R3] status-register ops wait for earlier fp ops, block later ones
// [R4] move-to-status-fields takes same time for any field mask
// [R5] fp moves copy data and never touch the status register
// [R6] move with record bit writes result status into field one
// [R7] accesses are issued and translated in program order
// [R8] misaligned access inside one double word takes one cycle, no exception
// [R9] access crossing a double word takes an extra access cycle
// [R10] string transfers issue one access per register, never merged
// [R11] software supplies aligned load/store multiple addresses
// [R12] page fault on second portion restarts the whole access
// [R13] translation reload is transparent, no restart
// [R14] little-endian misaligned single-register access raises no exception
// [R15] little-endian multiple or string access raises alignment exception
// [R16] fetch transactions never carry the coherence attribute
// [R17] fetch bypasses the data cache
// [R18] self-modifying code: flush, sync, invalidate, instruction sync
// [R19] address from reg+disp, reg+index, or reg only
// [R20] ordered compare also flags invalid on quiet nan
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fpls_params.svh"
module fpls_core
    import fpls_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        i_fp_busy,
    output logic             o_fetch_coherent,
    output logic             o_fetch_use_dcache
);
    typedef struct packed {
        logic [63:0] opa;
        logic [63:0] opb;
        logic [31:0] cmd;
        logic [31:0] fp_status_control_reg;
        logic [31:0] cond;
        logic [63:0] result;
        logic [31:0] addr;
        logic [31:0] index;
        logic [31:0] acc;
        logic [31:0] lsu_stat;
        fpls_state_t st;
        logic [3:0]  cnt;
        logic [7:0]  regs_left;
        logic        aw_hit;
        logic [7:0]  awaddr;
        logic        w_hit;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } fpls_state_s_t;

    fpls_state_s_t s;
    fpls_state_s_t next_s;

    // nan test on a double operand
    function automatic logic is_nan(input logic [63:0] v);
        is_nan = (&v[62:52]) && (|v[51:0]);
    endfunction : is_nan

    // byte-lane merge used by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    endfunction : merge

    // ieee compare: returns lt,gt,eq,un
    function automatic logic [3:0] fcompare(input logic [63:0] a, input logic [63:0] b);
        logic a_zero;
        logic b_zero;
        a_zero = (a[62:0] == 63'h0);
        b_zero = (b[62:0] == 63'h0);
        if (is_nan(a) || is_nan(b))
            fcompare = 4'h1;
        else if (a_zero && b_zero)
            fcompare = 4'h2;                     // [R1]
        else if (a == b)
            fcompare = 4'h2;
        else if (a[63] != b[63])
            fcompare = a[63] ? 4'h8 : 4'h4;
        else if (a[62:0] < b[62:0])
            fcompare = a[63] ? 4'h4 : 4'h8;
        else
            fcompare = a[63] ? 4'h8 : 4'h4;
    endfunction : fcompare

    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        start_cmd;
    logic        start_acc;
    logic [3:0]  cc;
    logic [3:0]  size;
    logic [2:0]  end_off;
    logic        crosses;
    fpls_op_t    op;
    fpls_kind_t  kind;
    fpls_mode_t  mode;
    logic [31:0] ea;

    // one write and one read at a time; address and data in either order
    assign o_awready = !s.aw_hit && !s.bvalid;
    assign o_wready  = !s.w_hit && !s.bvalid;
    assign o_arready = !s.rvalid;
    assign aw_take   = i_awvalid && o_awready;
    assign w_take    = i_wvalid && o_wready;
    assign ar_take   = i_arvalid && o_arready;
    assign o_bvalid  = s.bvalid;
    assign o_bresp   = s.bresp;
    assign o_rvalid  = s.rvalid;
    assign o_rresp   = s.rresp;
    assign o_rdata   = s.rdata;
    // fetches are plain, non-coherent and never look in the data cache
    assign o_fetch_coherent   = 1'b0;   // [R16]
    assign o_fetch_use_dcache = 1'b0;   // [R17]

    assign op   = fpls_op_t'(s.cmd[`FPLS_CMD_OP_LSB +: `FPLS_CMD_OP_W]);
    assign kind = fpls_kind_t'(s.acc[`FPLS_ACC_KIND_LSB +: 2]);
    assign mode = fpls_mode_t'(s.acc[`FPLS_ACC_MODE_LSB +: 2]);
    assign size = s.acc[`FPLS_ACC_SIZE_LSB +: `FPLS_ACC_SIZE_W];
    assign cc   = fcompare(s.opa, s.opb);

    // effective address modes
    always_comb
    begin
        case (mode)
            FPLS_M_DISP:  ea = s.addr + s.index;                // [R19]
            FPLS_M_INDEX: ea = s.addr + s.index;                // [R19]
            FPLS_M_REG:   ea = s.addr;                          // [R19]
            default:      ea = s.addr;
        endcase
    end
    assign end_off = 3'(ea[2:0] + size[2:0] - 3'h1);
    assign crosses = ({1'b0, ea[2:0]} + size) > 4'h8;           // [R8] [R9]

    // main next-state process
    always_comb
    begin
        logic [31:0] wd;
        logic [7:0]  wa;
        wd = s.w_hit ? s.wdata : i_wdata;
        wa = s.aw_hit ? s.awaddr : i_awaddr;
        next_s = s;
        start_cmd = 1'b0;
        start_acc = 1'b0;
        if (aw_take)
        begin
            next_s.aw_hit = 1'b1;
            next_s.awaddr = i_awaddr;
        end
        if (w_take)
        begin
            next_s.w_hit = 1'b1;
            next_s.wdata = i_wdata;
            next_s.wstrb = i_wstrb;
        end
        // register write once both halves are in
        if ((s.aw_hit || aw_take) && (s.w_hit || w_take) && !s.bvalid)
        begin
            logic [3:0] be;
            be = s.w_hit ? s.wstrb : i_wstrb;
            next_s.aw_hit = 1'b0;
            next_s.w_hit  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = 2'b00;
            case (wa)
                `FPLS_OFF_OPA_LO: next_s.opa[31:0]  = merge(s.opa[31:0], wd, be);
                `FPLS_OFF_OPA_HI: next_s.opa[63:32] = merge(s.opa[63:32], wd, be);
                `FPLS_OFF_OPB_LO: next_s.opb[31:0]  = merge(s.opb[31:0], wd, be);
                `FPLS_OFF_OPB_HI: next_s.opb[63:32] = merge(s.opb[63:32], wd, be);
                `FPLS_OFF_ADDR:   next_s.addr  = merge(s.addr, wd, be);
                `FPLS_OFF_INDEX:  next_s.index = merge(s.index, wd, be);
                `FPLS_OFF_CMD:
                begin
                    next_s.cmd = merge(s.cmd, wd, be);
                    start_cmd  = (s.st == FPLS_S_IDLE);
                end
                `FPLS_OFF_ACCESS:
                begin
                    next_s.acc = merge(s.acc, wd, be);
                    start_acc  = (s.st == FPLS_S_IDLE);
                end
                default:          next_s.bresp = 2'b10; // unmapped or read-only
            endcase
            // a command while busy is not started and gets an error response, yet still overwrites its register
            if ((wa == `FPLS_OFF_CMD || wa == `FPLS_OFF_ACCESS) && s.st != FPLS_S_IDLE)
                next_s.bresp = 2'b10;
        end
        if (s.bvalid && i_bready)
            next_s.bvalid = 1'b0;
        // register read
        if (ar_take)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = 2'b00;
            case (i_araddr)
                `FPLS_OFF_OPA_LO:    next_s.rdata = s.opa[31:0];
                `FPLS_OFF_OPA_HI:    next_s.rdata = s.opa[63:32];
                `FPLS_OFF_OPB_LO:    next_s.rdata = s.opb[31:0];
                `FPLS_OFF_OPB_HI:    next_s.rdata = s.opb[63:32];
                `FPLS_OFF_CMD:       next_s.rdata = s.cmd;
                `FPLS_OFF_STATUS:    next_s.rdata = {26'h0, s.st};
                `FPLS_OFF_FP_STATUS_CONTROL_REG:     next_s.rdata = s.fp_status_control_reg;
                `FPLS_OFF_COND:      next_s.rdata = s.cond;
                `FPLS_OFF_RESULT_LO: next_s.rdata = s.result[31:0];
                `FPLS_OFF_RESULT_HI: next_s.rdata = s.result[63:32];
                `FPLS_OFF_ADDR:      next_s.rdata = s.addr;
                `FPLS_OFF_ACCESS:    next_s.rdata = s.acc;
                `FPLS_OFF_LSU_STAT:  next_s.rdata = s.lsu_stat;
                `FPLS_OFF_INDEX:     next_s.rdata = s.index;
                default:
                begin
                    next_s.rdata = `FPLS_RESET_ZERO;
                    next_s.rresp = 2'b10;
                end
            endcase
        end
        else if (s.rvalid && i_rready)
            next_s.rvalid = 1'b0;

        // execution sequencer; one request at a time keeps program order
        case (s.st)
            FPLS_S_IDLE:
            begin
                if (start_cmd)
                begin
                    fpls_op_t nop;
                    nop = fpls_op_t'(wd[`FPLS_CMD_OP_LSB +: `FPLS_CMD_OP_W]);
                    // status-register ops wait for the fp pipe to drain
                    if (nop == FPLS_OP_MFFS || nop == FPLS_OP_MTFSF)
                        next_s.st = FPLS_S_DRAIN;                   // [R3]
                    else
                        next_s.st = FPLS_S_EXEC;
                    next_s.cnt = `FPLS_FP_LATENCY;                  // [R4]
                end
                else if (start_acc)
                begin
                    next_s.st  = FPLS_S_ACC1;                       // [R7]
                    next_s.regs_left = wd[23:16];
                    next_s.lsu_stat  = `FPLS_RESET_ZERO;
                end
            end
            FPLS_S_DRAIN:
                if (!i_fp_busy)
                    next_s.st = FPLS_S_EXEC;                        // [R3]
            FPLS_S_EXEC:
            begin
                // fixed latency whatever the field mask, so software timing is flat
                if (s.cnt != 4'h1)
                    next_s.cnt = 4'(s.cnt - 4'h1);                  // [R4]
                else
                begin
                    next_s.st = FPLS_S_IDLE;
                    case (op)
                        FPLS_OP_CMPU, FPLS_OP_CMPO:
                        begin
                            next_s.fp_status_control_reg[`FPLS_FPCC_LSB +: 4] = cc; // [R20]
                            if (op == FPLS_OP_CMPO && (is_nan(s.opa) || is_nan(s.opb)))
                            begin
                                next_s.fp_status_control_reg[`FPLS_VXVC_BIT] = 1'b1; // [R20]
                                next_s.fp_status_control_reg[`FPLS_FX_BIT]   = 1'b1;
                            end
                            // record form: field is written with junk on purpose
                            if (s.cmd[`FPLS_CMD_REC_BIT])
                                next_s.cond[31:28] = ~cc;           // [R2]
                            else
                                next_s.cond[31:28] = cc;
                        end
                        FPLS_OP_MR, FPLS_OP_NEG, FPLS_OP_ABS, FPLS_OP_NABS:
                        begin
                            // moves copy bits only; status register untouched
                            case (op)
                                FPLS_OP_NEG:  next_s.result = {~s.opb[63], s.opb[62:0]};
                                FPLS_OP_ABS:  next_s.result = {1'b0, s.opb[62:0]};
                                FPLS_OP_NABS: next_s.result = {1'b1, s.opb[62:0]};
                                default:      next_s.result = s.opb;    // [R5]
                            endcase
                            if (s.cmd[`FPLS_CMD_REC_BIT])
                                next_s.cond[27:24] = s.fp_status_control_reg[31:28];    // [R6]
                        end
                        FPLS_OP_MFFS:
                            next_s.result = {32'h0, s.fp_status_control_reg};       // [R3]
                        FPLS_OP_MTFSF:
                            for (int f = 0; f < 8; f++)
                                if (s.cmd[`FPLS_CMD_FM_LSB + f])
                                    next_s.fp_status_control_reg[f*4 +: 4] = s.opb[f*4 +: 4]; // [R4]
                        default: ;
                    endcase
                end
            end
            FPLS_S_ACC1:
            begin
                // little-endian multiple and string always trap
                if (s.acc[`FPLS_ACC_LE_BIT] && kind != FPLS_K_SINGLE)
                begin
                    next_s.lsu_stat[0] = 1'b1;                      // [R15]
                    next_s.st = FPLS_S_IDLE;
                end
                else if (kind != FPLS_K_SINGLE && ea[1:0] != 2'h0 && kind == FPLS_K_MULT)
                begin
                    next_s.lsu_stat[0] = 1'b1;                      // [R11]
                    next_s.st = FPLS_S_IDLE;
                end
                else if (s.acc[`FPLS_ACC_TLBM_BIT])
                begin
                    // reload walk; the access resumes, not restarts
                    next_s.acc[`FPLS_ACC_TLBM_BIT] = 1'b0;          // [R13]
                    next_s.cnt = `FPLS_TLB_RELOAD;
                    next_s.st  = FPLS_S_TLB;
                end
                else
                begin
                    next_s.lsu_stat[15:8] = 8'(s.lsu_stat[15:8] + 8'h1); // accesses
                    if (crosses && kind == FPLS_K_SINGLE)
                        next_s.st = FPLS_S_ACC2;                    // [R9]
                    else if (kind != FPLS_K_SINGLE && s.regs_left > 8'h1)
                    begin
                        // one access per register, never merged
                        next_s.regs_left = 8'(s.regs_left - 8'h1);  // [R10]
                        next_s.index = s.index + 32'h4;
                    end
                    else
                    begin
                        next_s.lsu_stat[1] = 1'b1;                  // [R8] [R14] done
                        next_s.st = FPLS_S_IDLE;
                    end
                end
            end
            FPLS_S_ACC2:
            begin
                if (s.acc[`FPLS_ACC_FAULT_BIT])
                begin
                    // fault on second half: rerun from the first portion
                    next_s.acc[`FPLS_ACC_FAULT_BIT] = 1'b0;         // [R12]
                    next_s.lsu_stat[2] = 1'b1;
                    next_s.st = FPLS_S_ACC1;
                end
                else
                begin
                    next_s.lsu_stat[15:8] = 8'(s.lsu_stat[15:8] + 8'h1);
                    next_s.lsu_stat[1] = 1'b1;
                    next_s.st = FPLS_S_IDLE;                        // [R9]
                end
            end
            FPLS_S_TLB:
                if (s.cnt != 4'h1)
                    next_s.cnt = 4'(s.cnt - 4'h1);
                else
                    next_s.st = FPLS_S_ACC1;                        // [R13]
            default:
                next_s.st = FPLS_S_IDLE;
        endcase
        next_s.lsu_stat[7:5] = end_off;
    end

    // state register, synchronous reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s    <= '0;
            s.st <= FPLS_S_IDLE;
        end
        else
            s <= next_s;
    end
endmodule : fpls_core
`default_nettype wire

/* verif/fpls_core_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module fpls_core_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic        o_fetch_coherent,
    input wire logic        o_fetch_use_dcache
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // both halves of a write taken at one edge
    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence

    a_fetch_no_coh: assert property (o_fetch_coherent == 1'b0)
        else $error("fetch carries coherence attribute");
    a_fetch_bypass: assert property (o_fetch_use_dcache == 1'b0)
        else $error("fetch goes through data cache");
    a_wr_answer: assert property (s_wr_taken |=> o_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_rd_taken |=> o_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    a_b_blocks_aw: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted during response");
    a_b_release: assert property (o_bvalid && i_bready |=> !o_bvalid)
        else $error("write response repeated");
endmodule : fpls_core_monitor

bind fpls_core fpls_core_monitor u_fpls_core_monitor (
    .i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_fetch_coherent(o_fetch_coherent),
    .o_fetch_use_dcache(o_fetch_use_dcache));
`default_nettype wire

/* verif/fpls_fp_busy_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fpls_fp_busy_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_len,
    input  wire logic       i_kick,
    output logic            o_busy
);
    logic [7:0] left;
    // fp ops in flight for i_len cycles after a kick
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            left <= 8'h00;
        else if (i_kick)
            left <= i_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    assign o_busy = (left != 8'h00);
endmodule : fpls_fp_busy_model
`default_nettype wire

/* verif/fpls_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fpls_params.svh"
module fpls_core_tb
    import fpls_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, kick_len = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, kick = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, fp_busy, f_coh, f_dc;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd, f0;
    int          failures = 0, num_checks = 0;
    fpls_op_t    mv_op[4] = '{FPLS_OP_MR, FPLS_OP_NEG, FPLS_OP_ABS, FPLS_OP_NABS};
    logic [31:0] mv_hi[4] = '{32'h8123_4567, 32'h0123_4567, 32'h0123_4567, 32'h8123_4567};

    always #5 i_clk = ~i_clk;

    fpls_fp_busy_model u_fpls_fp_busy_model (.i_clk(i_clk), .i_rst(i_rst), .i_len(kick_len),
        .i_kick(kick), .o_busy(fp_busy));
    fpls_core u_fpls_core (.i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_fp_busy(fp_busy), .o_fetch_coherent(f_coh), .o_fetch_use_dcache(f_dc));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // requests stand until ready is seen at a rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wait_idle(output int n);
        n = 0;
        do
        begin
            axi_rd(`FPLS_OFF_STATUS);
            n++;
        end
        while (rd !== 32'h1 && n < 100);
        chk("status idle", rd, 32'h1);
    endtask : wait_idle

    task automatic fp_op(input logic [63:0] a, input logic [63:0] b, input logic [31:0] c);
        int n;
        axi_wr(`FPLS_OFF_OPA_LO, a[31:0]);
        axi_wr(`FPLS_OFF_OPA_HI, a[63:32]);
        axi_wr(`FPLS_OFF_OPB_LO, b[31:0]);
        axi_wr(`FPLS_OFF_OPB_HI, b[63:32]);
        axi_wr(`FPLS_OFF_CMD, c);
        wait_idle(n);
        axi_rd(`FPLS_OFF_FP_STATUS_CONTROL_REG);
    endtask : fp_op

    task automatic lsu(input logic [31:0] b, input logic [31:0] x, input logic [31:0] acc,
                       input logic [31:0] m, input logic [31:0] e);
        int n;
        axi_wr(`FPLS_OFF_INDEX, x);
        axi_wr(`FPLS_OFF_ADDR, b);
        axi_wr(`FPLS_OFF_ACCESS, acc);
        wait_idle(n);
        axi_rd(`FPLS_OFF_LSU_STAT);
        chk("lsu status", rd & m, e);
    endtask : lsu

    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // a hang counts as a failure
    initial
    begin
        #300000;
        failures++;
        $display("unexpected watchdog: expected done seen hang");
        test_done();
    end

    initial
    begin
        int n1, n2;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        axi_rd(`FPLS_OFF_STATUS);
        chk("status reset", rd, 32'h1);
        axi_rd(8'h40);
        chk("unmapped rresp", {30'h0, resp}, 32'h2);
        axi_wr(`FPLS_OFF_FP_STATUS_CONTROL_REG, 32'hffff_ffff);
        chk("read-only bresp", {30'h0, resp}, 32'h2);
        chk("fetch attrs", {30'h0, f_coh, f_dc}, 32'h0);
        $display("test registers done");
        fp_op(64'h0, 64'h8000_0000_0000_0000, {28'h0, FPLS_OP_CMPU});
        chk("zero fpcc", {28'h0, rd[15:12]}, 32'h2);
        fp_op(64'h7ff8_0000_0000_0000, 64'h0, {28'h0, FPLS_OP_CMPU});
        chk("cmpu nan", {rd[31], rd[19], 26'h0, rd[15:12]}, 32'h1);
        fp_op(64'h7ff8_0000_0000_0000, 64'h0, {28'h0, FPLS_OP_CMPO});
        chk("cmpo nan", {rd[31], rd[19], 26'h0, rd[15:12]}, 32'hc000_0001);
        fp_op(64'h0, 64'h0, {27'h0, 1'b1, FPLS_OP_CMPU});
        f0 = rd;
        for (int i = 0; i < 4; i++)
        begin
            fp_op(64'h0, 64'h8123_4567_89ab_cdef, {28'h0, mv_op[i]});
            chk("move fp_status_control_reg", rd, f0);
            axi_rd(`FPLS_OFF_RESULT_HI);
            chk("move hi", rd, mv_hi[i]);
            axi_rd(`FPLS_OFF_RESULT_LO);
            chk("move lo", rd, 32'h89ab_cdef);
        end
        fp_op(64'h0, 64'h0, {27'h0, 1'b1, FPLS_OP_MR});
        axi_rd(`FPLS_OFF_COND);
        chk("cond field one", {28'h0, rd[27:24]}, {28'h0, f0[31:28]});
        $display("test fp ops done");
        kick <= 1'b1;
        kick_len <= 8'h28;
        @(posedge i_clk);
        kick <= 1'b0;
        axi_wr(`FPLS_OFF_CMD, {28'h0, FPLS_OP_MFFS});
        axi_rd(`FPLS_OFF_STATUS);
        chk("status drain", rd, 32'h2);
        axi_wr(`FPLS_OFF_CMD, {28'h0, FPLS_OP_MR});
        chk("cmd refused", {30'h0, resp}, 32'h2);
        wait_idle(n1);
        chk("busy gone", {31'h0, fp_busy}, 32'h0);
        axi_wr(`FPLS_OFF_CMD, {16'h0, 8'hff, 4'h0, FPLS_OP_MTFSF});
        wait_idle(n1);
        axi_wr(`FPLS_OFF_CMD, {16'h0, 8'h01, 4'h0, FPLS_OP_MTFSF});
        wait_idle(n2);
        chk("mtfsf polls", n2, n1);
        $display("test sync done");
        lsu(32'h1, 32'h0, 32'h0000_0004, 32'hffe3, 32'h0182);
        lsu(32'h6, 32'h0, 32'h0000_0004, 32'hff03, 32'h0202);
        lsu(32'h6, 32'h0, 32'h0000_2004, 32'h0007, 32'h0006);
        lsu(32'h6, 32'h0, 32'h0000_4004, 32'h0007, 32'h0002);
        lsu(32'h1, 32'h0, 32'h0000_1004, 32'h0001, 32'h0000);
        lsu(32'h0, 32'h0, 32'h0002_1014, 32'h0001, 32'h0001);
        lsu(32'h0, 32'h0, 32'h0002_1024, 32'h0001, 32'h0001);
        lsu(32'h0, 32'h0, 32'h0002_0014, 32'h0001, 32'h0000);
        lsu(32'h0, 32'h0, 32'h0003_0024, 32'hff03, 32'h0302);
        lsu(32'h0, 32'h2, 32'h0000_0002, 32'h00e0, 32'h0060);
        lsu(32'h0, 32'h2, 32'h0000_0102, 32'h00e0, 32'h0060);
        lsu(32'h0, 32'h2, 32'h0000_0202, 32'h00e0, 32'h0020);
        $display("test load store done");
        test_done();
    end
endmodule : fpls_core_tb
`default_nettype wire
